/* File: rtl/tof_pkg.sv */
// Package with register map, field layout and carrier types of the fault flag bank.
package tof_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_CRIT = 8'hb4;
  localparam logic [ADDR_W-1:0] OFS_HOT  = 8'hb5;
  localparam logic [ADDR_W-1:0] OFS_OC   = 8'hb6;

  // Field widths and reset values.
  localparam int unsigned N_TEMP = 5;
  localparam int unsigned N_OC   = 3;
  localparam logic [N_TEMP-1:0] TEMP_RESET = 5'h00;
  localparam logic [N_OC-1:0]   OC_RESET   = 3'h0;

  // Bit positions of the temperature sensors within the hot and critical registers.
  localparam int unsigned BIT_BOTTOM_RIGHT = 0;
  localparam int unsigned BIT_TOP_LEFT     = 1;
  localparam int unsigned BIT_TOP_RIGHT    = 2;
  localparam int unsigned BIT_TERM_REG     = 3;
  localparam int unsigned BIT_REST_OF_DIE  = 4;

  // Bit positions of the overcurrent rails.
  localparam int unsigned BIT_CTRL_ONE = 0;
  localparam int unsigned BIT_CTRL_TWO = 1;
  localparam int unsigned BIT_CTRL_SIX = 2;

  // Register bus request carrier.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tof_req_t;

  // Per-sensor threshold alerts.
  typedef struct packed {
    logic rest_of_die;
    logic term_reg;
    logic top_right;
    logic top_left;
    logic bottom_right;
  } tof_temp_t;

endpackage

/* File: rtl/tof_flag_reg.sv */
// Sticky write-one-to-clear flag register with a two-stage input synchroniser.
`timescale 1ns/1ps
module tof_flag_reg
  import tof_pkg::*;
#(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] event_async,
  input  wire logic             clr_en,
  input  wire logic [WIDTH-1:0] clr_mask,
  output logic      [WIDTH-1:0] flags
);

  initial begin
    if (WIDTH < 1 || WIDTH > DATA_W) $error("tof_flag_reg: WIDTH out of range");
  end

  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // Alerts come from analog comparators, so they pass two flops first.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= event_async;
      sync2_r <= sync1_r;
    end
  end

  // Set wins over clear so a fault arriving during a clear is never lost.
  always_comb begin
    flags_nxt = flags_r;
    if (clr_en) begin
      flags_nxt = flags_r & ~clr_mask;
    end
    flags_nxt = flags_nxt | sync2_r;
  end

  // Flag storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
      (flags_r != '0 && !clr_en) |=> ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      (sync2_r != '0) |=> ((flags_r & $past(sync2_r)) == $past(sync2_r));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      (clr_en && sync2_r == '0) |=> ((flags_r & $past(clr_mask)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear");

  property p_zero_keeps;
    @(posedge clk) disable iff (!rst_n)
      clr_en |=> ((flags_r & ~$past(clr_mask))
                  == (($past(flags_r) | $past(sync2_r)) & ~$past(clr_mask)));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed flag");

endmodule

/* File: rtl/tof_fault_flags.sv */
// Top of the thermal and overcurrent sticky fault flag register bank.
`timescale 1ns/1ps
module tof_fault_flags
  import tof_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire tof_temp_t         HOT_ALERT,
  input  wire tof_temp_t         CRIT_ALERT,
  input  wire logic [N_OC-1:0]   OC_ALERT
);

  tof_req_t          req;
  logic [N_TEMP-1:0] hot_flags;
  logic [N_TEMP-1:0] crit_flags;
  logic [N_OC-1:0]   oc_flags;
  logic [N_TEMP-1:0] hot_in;
  logic [N_TEMP-1:0] crit_in;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Map each sensor onto its own bit of the hot and critical registers.
  always_comb begin
    hot_in                   = '0;
    crit_in                  = '0;
    hot_in[BIT_REST_OF_DIE]  = HOT_ALERT.rest_of_die;
    hot_in[BIT_TERM_REG]     = HOT_ALERT.term_reg;
    hot_in[BIT_TOP_RIGHT]    = HOT_ALERT.top_right;
    hot_in[BIT_TOP_LEFT]     = HOT_ALERT.top_left;
    hot_in[BIT_BOTTOM_RIGHT] = HOT_ALERT.bottom_right;
    crit_in                  = {CRIT_ALERT.rest_of_die, CRIT_ALERT.term_reg,
                                CRIT_ALERT.top_right, CRIT_ALERT.top_left,
                                CRIT_ALERT.bottom_right};
  end

  // Critical temperature flags share the hot register's layout.
  tof_flag_reg #(.WIDTH(N_TEMP)) u_crit (
    .clk         (CLOCK),
    .rst_n       (RST_N),
    .event_async (crit_in),
    .clr_en      (req.wr && req.addr == OFS_CRIT),
    .clr_mask    (req.wdata[N_TEMP-1:0]),
    .flags       (crit_flags)
  );

  // Hot temperature flags.
  tof_flag_reg #(.WIDTH(N_TEMP)) u_hot (
    .clk         (CLOCK),
    .rst_n       (RST_N),
    .event_async (hot_in),
    .clr_en      (req.wr && req.addr == OFS_HOT),
    .clr_mask    (req.wdata[N_TEMP-1:0]),
    .flags       (hot_flags)
  );

  // Low-side switch overcurrent flags, bit order follows the rail table.
  tof_flag_reg #(.WIDTH(N_OC)) u_oc (
    .clk         (CLOCK),
    .rst_n       (RST_N),
    .event_async (OC_ALERT),
    .clr_en      (req.wr && req.addr == OFS_OC),
    .clr_mask    (req.wdata[N_OC-1:0]),
    .flags       (oc_flags)
  );

  // Read mux; reserved bits and unmapped addresses return zero.
  always_comb begin
    rdata_nxt = '0;
    if (req.rd) begin
      unique case (req.addr)
        OFS_CRIT: rdata_nxt = {3'h0, crit_flags};
        OFS_HOT:  rdata_nxt = {3'h0, hot_flags};
        OFS_OC:   rdata_nxt = {5'h00, oc_flags};
        default:  rdata_nxt = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  property p_hot_reserved;
    @(posedge CLOCK) disable iff (!RST_N)
      (RD && ADDR == OFS_HOT) |=> (RDATA[7:5] == 3'h0 && RDATA[4:0] == $past(hot_flags));
  endproperty
  a_hot_reserved: assert property (p_hot_reserved) else $error("hot readback wrong");

  property p_oc_reserved;
    @(posedge CLOCK) disable iff (!RST_N)
      (RD && ADDR == OFS_OC) |=> (RDATA[7:3] == 5'h00 && RDATA[2:0] == $past(oc_flags));
  endproperty
  a_oc_reserved: assert property (p_oc_reserved) else $error("oc readback wrong");

  property p_die_hot;
    @(posedge CLOCK) disable iff (!RST_N)
      HOT_ALERT.rest_of_die [*4] |-> hot_flags[BIT_REST_OF_DIE];
  endproperty
  a_die_hot: assert property (p_die_hot) else $error("rest of die hot not flagged");

  property p_term_hot;
    @(posedge CLOCK) disable iff (!RST_N)
      HOT_ALERT.term_reg [*4] |-> hot_flags[BIT_TERM_REG];
  endproperty
  a_term_hot: assert property (p_term_hot) else $error("regulator hot not flagged");

  property p_corner_hot;
    @(posedge CLOCK) disable iff (!RST_N)
      HOT_ALERT.top_right [*4] |-> hot_flags[BIT_TOP_RIGHT];
  endproperty
  a_corner_hot: assert property (p_corner_hot) else $error("corner hot not flagged");

  property p_oc_six;
    @(posedge CLOCK) disable iff (!RST_N)
      OC_ALERT[BIT_CTRL_SIX] [*4] |-> oc_flags[BIT_CTRL_SIX];
  endproperty
  a_oc_six: assert property (p_oc_six) else $error("rail six overcurrent missed");

  property p_crit_die;
    @(posedge CLOCK) disable iff (!RST_N)
      CRIT_ALERT.rest_of_die [*4] |-> crit_flags[BIT_REST_OF_DIE];
  endproperty
  a_crit_die: assert property (p_crit_die) else $error("critical not flagged");

  property p_independent;
    @(posedge CLOCK) disable iff (!RST_N)
      (HOT_ALERT == '0) [*4] |-> (hot_flags & ~$past(hot_flags)) == '0;
  endproperty
  a_independent: assert property (p_independent) else $error("hot flag set with no alert");

  // An alert needs two synchroniser flops and the flag flop, so four samples prove it.
  property p_corner_left;
    @(posedge CLOCK) disable iff (!RST_N)
      HOT_ALERT.top_left [*4] |-> hot_flags[BIT_TOP_LEFT];
  endproperty
  a_corner_left: assert property (p_corner_left) else $error("top left hot missed");

  // Bottom-right corner sensor reaches its own hot bit.
  property p_corner_bottom;
    @(posedge CLOCK) disable iff (!RST_N)
      HOT_ALERT.bottom_right [*4] |-> hot_flags[BIT_BOTTOM_RIGHT];
  endproperty
  a_corner_bottom: assert property (p_corner_bottom) else $error("bottom hot missed");

  // Critical regulator sensor uses the hot register's bit position.
  property p_crit_term;
    @(posedge CLOCK) disable iff (!RST_N)
      CRIT_ALERT.term_reg [*4] |-> crit_flags[BIT_TERM_REG];
  endproperty
  a_crit_term: assert property (p_crit_term) else $error("critical regulator missed");

  // Critical top-right sensor.
  property p_crit_right;
    @(posedge CLOCK) disable iff (!RST_N)
      CRIT_ALERT.top_right [*4] |-> crit_flags[BIT_TOP_RIGHT];
  endproperty
  a_crit_right: assert property (p_crit_right) else $error("critical top right missed");

  // Critical top-left sensor.
  property p_crit_left;
    @(posedge CLOCK) disable iff (!RST_N)
      CRIT_ALERT.top_left [*4] |-> crit_flags[BIT_TOP_LEFT];
  endproperty
  a_crit_left: assert property (p_crit_left) else $error("critical top left missed");

  // Critical bottom-right sensor.
  property p_crit_bottom;
    @(posedge CLOCK) disable iff (!RST_N)
      CRIT_ALERT.bottom_right [*4] |-> crit_flags[BIT_BOTTOM_RIGHT];
  endproperty
  a_crit_bottom: assert property (p_crit_bottom) else $error("critical bottom missed");

  // Rail two overcurrent lands on bit 1.
  property p_oc_two;
    @(posedge CLOCK) disable iff (!RST_N)
      OC_ALERT[BIT_CTRL_TWO] [*4] |-> oc_flags[BIT_CTRL_TWO];
  endproperty
  a_oc_two: assert property (p_oc_two) else $error("rail two overcurrent missed");

  // Rail one overcurrent lands on bit 0.
  property p_oc_one;
    @(posedge CLOCK) disable iff (!RST_N)
      OC_ALERT[BIT_CTRL_ONE] [*4] |-> oc_flags[BIT_CTRL_ONE];
  endproperty
  a_oc_one: assert property (p_oc_one) else $error("rail one overcurrent missed");

  // Critical readback keeps its reserved bits at zero.
  property p_crit_reserved;
    @(posedge CLOCK) disable iff (!RST_N)
      (RD && ADDR == OFS_CRIT) |=> (RDATA[7:5] == 3'h0 && RDATA[4:0] == $past(crit_flags));
  endproperty
  a_crit_reserved: assert property (p_crit_reserved) else $error("crit readback wrong");

  // Unmapped addresses answer zero so software never sees stale flags.
  property p_unmapped_read;
    @(posedge CLOCK) disable iff (!RST_N)
      (RD && ADDR != OFS_CRIT && ADDR != OFS_HOT && ADDR != OFS_OC) |=> RDATA == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Read data stand for one cycle only.
  property p_idle_rdata;
    @(posedge CLOCK) disable iff (!RST_N)
      !RD |=> RDATA == 8'h00;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data left standing");

  // No overcurrent flag appears once every rail has been quiet for four samples.
  property p_oc_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
      (OC_ALERT == '0) [*4] |-> (oc_flags & ~$past(oc_flags)) == '0;
  endproperty
  a_oc_quiet: assert property (p_oc_quiet) else $error("oc flag set with no alert");

  // No critical flag appears once every sensor has been below threshold for four samples.
  property p_crit_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
      (CRIT_ALERT == '0) [*4] |-> (crit_flags & ~$past(crit_flags)) == '0;
  endproperty
  a_crit_quiet: assert property (p_crit_quiet) else $error("crit flag set with no alert");

  // With the synchronisers empty, a written one clears its hot flag.
  property p_hot_clear;
    @(posedge CLOCK) disable iff (!RST_N)
      (HOT_ALERT == '0) [*2] ##1 (WR && ADDR == OFS_HOT && HOT_ALERT == '0)
        |=> (hot_flags & $past(WDATA[N_TEMP-1:0])) == '0;
  endproperty
  a_hot_clear: assert property (p_hot_clear) else $error("hot flag not cleared");

  // Same for the overcurrent register.
  property p_oc_clear;
    @(posedge CLOCK) disable iff (!RST_N)
      (OC_ALERT == '0) [*2] ##1 (WR && ADDR == OFS_OC && OC_ALERT == '0)
        |=> (oc_flags & $past(WDATA[N_OC-1:0])) == '0;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("oc flag not cleared");

  // Same for the critical register.
  property p_crit_clear;
    @(posedge CLOCK) disable iff (!RST_N)
      (CRIT_ALERT == '0) [*2] ##1 (WR && ADDR == OFS_CRIT && CRIT_ALERT == '0)
        |=> (crit_flags & $past(WDATA[N_TEMP-1:0])) == '0;
  endproperty
  a_crit_clear: assert property (p_crit_clear) else $error("crit flag not cleared");

  // A zero in the write data leaves that hot flag as it was.
  property p_hot_keep;
    @(posedge CLOCK) disable iff (!RST_N)
      (WR && ADDR == OFS_HOT)
        |=> ($past(hot_flags) & ~$past(WDATA[N_TEMP-1:0]) & ~hot_flags) == '0;
  endproperty
  a_hot_keep: assert property (p_hot_keep) else $error("hot flag lost on zero");

  // A zero in the write data leaves that overcurrent flag as it was.
  property p_oc_keep;
    @(posedge CLOCK) disable iff (!RST_N)
      (WR && ADDR == OFS_OC)
        |=> ($past(oc_flags) & ~$past(WDATA[N_OC-1:0]) & ~oc_flags) == '0;
  endproperty
  a_oc_keep: assert property (p_oc_keep) else $error("oc flag lost on zero");

  // A zero in the write data leaves that critical flag as it was.
  property p_crit_keep;
    @(posedge CLOCK) disable iff (!RST_N)
      (WR && ADDR == OFS_CRIT)
        |=> ($past(crit_flags) & ~$past(WDATA[N_TEMP-1:0]) & ~crit_flags) == '0;
  endproperty
  a_crit_keep: assert property (p_crit_keep) else $error("crit flag lost on zero");

  // Without a write to its address a hot flag never drops.
  property p_hot_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      !(WR && ADDR == OFS_HOT) |=> ($past(hot_flags) & ~hot_flags) == '0;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("hot flag dropped");

  // Without a write to its address an overcurrent flag never drops.
  property p_oc_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      !(WR && ADDR == OFS_OC) |=> ($past(oc_flags) & ~oc_flags) == '0;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("oc flag dropped");

  // Without a write to its address a critical flag never drops.
  property p_crit_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      !(WR && ADDR == OFS_CRIT) |=> ($past(crit_flags) & ~crit_flags) == '0;
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("crit flag dropped");

  // A clear that meets a still-held alert loses to it.
  property p_hot_wins;
    @(posedge CLOCK) disable iff (!RST_N)
      HOT_ALERT.term_reg [*3] ##1 (WR && ADDR == OFS_HOT && WDATA[BIT_TERM_REG])
        |=> hot_flags[BIT_TERM_REG];
  endproperty
  a_hot_wins: assert property (p_hot_wins) else $error("clear beat a held alert");

  // Reset empties every register and the read port; no disable, reset is the trigger.
  property p_reset_clear;
    @(posedge CLOCK)
      !RST_N |=> (hot_flags == '0 && crit_flags == '0 && oc_flags == '0 && RDATA == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

endmodule

/* File: testbench/tof_host.sv */
// Host model that reads and clears the fault flags over the plain register port.
`timescale 1ns/1ps
module tof_host
  import tof_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic [DATA_W-1:0] RDATA,
  output logic      [ADDR_W-1:0] ADDR,
  output logic      [DATA_W-1:0] WDATA,
  output logic                   WR,
  output logic                   RD
);
  // Idle bus at time zero so no strobe is ever unknown.
  initial begin
    ADDR  = 8'h00;
    WDATA = 8'h00;
    WR    = 1'b0;
    RD    = 1'b0;
  end

  // One-cycle write; a one in the data clears that flag.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLOCK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
    WDATA <= ~d; // Stale data is scrambled so nothing leans on it.
  endtask

  // One-cycle read; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLOCK);
    RD   <= 1'b0;
    ADDR <= ~a;
    #1;
    d = RDATA;
  endtask
endmodule

/* File: testbench/thermal_overcurrent_fault_flags_tb.sv */
// Self-checking bench of the fault flag bank against an integer flag model.
`timescale 1ns/1ps
module thermal_overcurrent_fault_flags_tb
  import tof_pkg::*;
;
  logic              CLOCK = 1'b0;
  logic              RST_N = 1'b0;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA;
  logic              WR;
  logic              RD;
  logic [DATA_W-1:0] RDATA;
  tof_temp_t         HOT_ALERT;
  tof_temp_t         CRIT_ALERT;
  logic [N_OC-1:0]   OC_ALERT;
  int                fails = 0;
  int                n_tests = 0;
  int                cycles = 0;
  int                m [3];
  int                a [3];
  int                idx;
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] msk;

  // Free-running clock at 250 MHz.
  always #2 CLOCK = ~CLOCK;

  tof_fault_flags uut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .HOT_ALERT(HOT_ALERT), .CRIT_ALERT(CRIT_ALERT),
    .OC_ALERT(OC_ALERT));
  tof_host host (.CLOCK(CLOCK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));

  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Read one register and compare it with the model value.
  task automatic rdchk(input logic [ADDR_W-1:0] ad, input int e);
    host.rd(ad, got);
    n_tests++;
    if (got !== 8'(e)) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, 8'(e));
    end
    // The read data must be gone one cycle later.
    @(posedge CLOCK);
    #1;
    n_tests++;
    if (RDATA !== 8'h00) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, RDATA, 8'h00);
    end
  endtask

  // All three flag registers plus an unmapped place that must read zero.
  task automatic cmpall();
    rdchk(OFS_CRIT, m[0]);
    rdchk(OFS_HOT, m[1]);
    rdchk(OFS_OC, m[2]);
    rdchk(8'hb7, 0);
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // Main sequence: random alerts, clears under held alerts, and a second reset.
  initial begin
    void'($urandom(32'h7724502f));
    HOT_ALERT  = '0;
    CRIT_ALERT = '0;
    OC_ALERT   = '0;
    m = '{0, 0, 0};
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    cmpall();
    for (int k = 0; k < 40; k++) begin
      a[0] = 5'($urandom);
      a[1] = 5'($urandom);
      a[2] = 3'($urandom);
      msk = (k % 5 == 0) ? 8'h00 : 8'($urandom);
      idx = k % 4;
      @(posedge CLOCK);
      CRIT_ALERT <= tof_temp_t'(5'(a[0]));
      HOT_ALERT  <= tof_temp_t'(5'(a[1]));
      OC_ALERT   <= 3'(a[2]);
      repeat (4) @(posedge CLOCK);
      for (int i = 0; i < 3; i++) m[i] |= a[i];
      // Clear while the alert is still high: set must win.
      host.wr(OFS_CRIT + 8'(idx), msk);
      if (idx < 3) m[idx] = (m[idx] & ~int'(msk)) | a[idx];
      @(posedge CLOCK);
      HOT_ALERT  <= '0;
      CRIT_ALERT <= '0;
      OC_ALERT   <= '0;
      repeat (4) @(posedge CLOCK);
      cmpall();
    end
    @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLOCK);
    RST_N <= 1'b1;
    m = '{0, 0, 0};
    cmpall();
    summarize();
  end
endmodule
